// ==== rtl/dcpc_cal_engine.sv ====
// Calibration clock divider and calibration cycle sequencer
`include "dcpc_defines.svh"
`default_nettype none
module dcpc_cal_engine (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Control
  input wire logic clk_en,
  input wire logic [2:0] div,
  input wire logic start,
  input wire logic clear,
  input wire dcpc_pkg::dcpc_cal_res_t meas,
  // Results
  output dcpc_pkg::dcpc_cal_res_t res,
  output logic done,
  output logic cal_tick
);
  import dcpc_pkg::*;

  dcpc_cal_state_t q;
  dcpc_cal_state_t d;
  logic [7:0] div_lim;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    div_lim = 8'((8'h01 << div) - 8'h01);
    // Calibration clock is the DAC clock divided by 2 to the power div
    if (clk_en)
    begin
      if (q.div_cnt >= div_lim)
      begin
        d.div_cnt = 8'h00;
        d.tick = 1'b1;
      end
      else
        d.div_cnt = q.div_cnt + 8'h01;
    end
    else
      d.div_cnt = 8'h00;
    // Clear comes first so a finishing cycle in the same clock wins
    if (clear)
    begin
      d.res = '0;
      d.done = 1'b0;
    end
    unique case (q.st)
      CAL_IDLE:
        if (start)
        begin
          d.st = CAL_RUN;
          d.ticks = 5'h00;
          d.done = 1'b0;
        end
      CAL_RUN:
        if (q.tick)
        begin
          if (q.ticks == `DCPC_CAL_TICKS - 5'h01)
          begin
            d.st = CAL_IDLE;
            d.res = meas;
            d.done = 1'b1;
          end
          else
            d.ticks = q.ticks + 5'h01;
        end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
      q.st <= CAL_IDLE;
    end
    else
      q <= d;
  end

  assign res = q.res;
  assign done = q.done;
  assign cal_tick = q.tick;
endmodule
`default_nettype wire

// ==== rtl/dcpc_defines.svh ====
// Register offsets, field positions, reset values and counts of the control bank
`ifndef DCPC_DEFINES_SVH
`define DCPC_DEFINES_SVH

// Register offsets on the serial register port
`define DCPC_OFS_REF 7'h03
`define DCPC_OFS_GAIN 7'h07
`define DCPC_OFS_RANGE 7'h08
`define DCPC_OFS_RSET 7'h0c
`define DCPC_OFS_CAL 7'h0d
`define DCPC_OFS_COFS 7'h0e
`define DCPC_OFS_UPD 7'h1d
`define DCPC_OFS_STAT 7'h1e
`define DCPC_OFS_TYPE 7'h1f
`define DCPC_OFS_DLY 7'h20
`define DCPC_OFS_RPT 7'h2b

// Field positions
`define DCPC_REF_LSB 0
`define DCPC_GAIN_LSB 0
`define DCPC_GAIN_CAL_LSB 8
`define DCPC_RANGE_LSB 0
`define DCPC_RSET_EN_BIT 15
`define DCPC_RSET_CAL_LSB 8
`define DCPC_RSET_LSB 0
`define DCPC_FLAG_LSB 9
`define DCPC_CAL_RESET_BIT 8
`define DCPC_CAL_MODE_BIT 7
`define DCPC_CAL_EN_BIT 6
`define DCPC_CAL_RNG_LSB 4
`define DCPC_CAL_CLK_EN_BIT 3
`define DCPC_CAL_DIV_LSB 0
`define DCPC_COFS_RES_LSB 8
`define DCPC_CAL_DONE_BIT 1
`define DCPC_START_BIT 0
`define DCPC_UPD_BIT 0
`define DCPC_BUF_READ_BIT 3
`define DCPC_MEM_BIT 2
`define DCPC_PAT_BIT 1
`define DCPC_RUN_BIT 0
`define DCPC_RPT_MODE_BIT 0
`define DCPC_DLY_LSB 0
`define DCPC_RPT_LSB 0

// Reset values
`define DCPC_RSET_RST 5'h0a
`define DCPC_DLY_RST 16'h000e
`define DCPC_RPT_RST 8'h01

// Calibration clock ticks taken by one calibration cycle
`define DCPC_CAL_TICKS 5'h10

`endif

// ==== rtl/dcpc_pkg.sv ====
// Types shared by the control bank and its calibration engine
`default_nettype none
package dcpc_pkg;

  // One request from the serial port core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } dcpc_reg_req_t;

  // Settings that exist as a pending and an active copy
  typedef struct packed {
    logic [5:0] ref_level_trim;
    logic [6:0] gain;
    logic [1:0] gain_range_select;
    logic internal_resistor_enable;
    logic [4:0] resistor_select;
    logic repeat_mode_select;
    logic [15:0] delay;
    logic [7:0] repeat_cnt;
  } dcpc_cfg_t;

  // Calibration results; flags ordered as in bits 14..9
  typedef struct packed {
    logic [6:0] gain;
    logic [4:0] resistor;
    logic [6:0] offset;
    logic [5:0] flags;
  } dcpc_cal_res_t;

  typedef enum logic [2:0] {
    PAT_IDLE = 3'b001,
    PAT_DELAY = 3'b010,
    PAT_PLAY = 3'b100
  } dcpc_pat_st_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } dcpc_cal_st_t;

  // Whole state of the calibration engine
  typedef struct packed {
    dcpc_cal_st_t st;
    logic [7:0] div_cnt;
    logic [4:0] ticks;
    logic tick;
    dcpc_cal_res_t res;
    logic done;
  } dcpc_cal_state_t;

  // Whole state of the register bank
  typedef struct packed {
    dcpc_cfg_t pend;
    dcpc_cfg_t act;
    logic cal_reset;
    logic cal_en;
    logic [1:0] cal_rng;
    logic cal_clk_en;
    logic [2:0] cal_div;
    logic start_cal;
    logic upd;
    logic buf_read;
    logic mem_access;
    logic run;
    dcpc_pat_st_t pst;
    logic trig_q;
    logic [15:0] dcnt;
    logic [7:0] rcnt;
    logic start_p;
    logic [6:0] gain_eff;
    logic [4:0] rset_eff;
    logic [15:0] rdata;
    logic rvalid;
  } dcpc_state_t;

endpackage
`default_nettype wire

// ==== rtl/dcpc_regs.sv ====
// Control and status register bank of the DAC: trims, calibration and playback control
`include "dcpc_defines.svh"
`default_nettype none
module dcpc_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port from the serial port core
  input wire dcpc_pkg::dcpc_reg_req_t reg_req,
  output logic [15:0] rdata,
  output logic rvalid,
  // Analog control
  output dcpc_pkg::dcpc_cfg_t act_cfg,
  output logic [6:0] gain_eff,
  output logic [4:0] rset_eff,
  output logic cal_mode,
  output logic cal_en,
  output logic [1:0] cal_rng,
  output logic cal_tick,
  input wire dcpc_pkg::dcpc_cal_res_t cal_meas,
  // Pattern control
  input wire logic trigger_n,
  input wire logic pat_end,
  output logic mem_access,
  output logic pattern_active,
  output logic pattern_start
);
  import dcpc_pkg::*;

  dcpc_state_t q;
  dcpc_state_t d;
  dcpc_cal_res_t cal_res;
  logic cal_done;
  logic cal_start;
  logic cal_clear;
  logic wr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Readback of one register
  function automatic logic [15:0] read_word(
    input logic [6:0] addr,
    input dcpc_state_t s,
    input dcpc_cal_res_t r,
    input logic fin,
    input logic mode
  );
    dcpc_cfg_t v;
    logic [15:0] w;
    w = 16'h0000;
    // Pending copy unless the host asked for the active one
    v = s.buf_read ? s.act : s.pend;
    unique case (addr)
      `DCPC_OFS_REF:
        w[`DCPC_REF_LSB +: 6] = v.ref_level_trim;
      `DCPC_OFS_GAIN:
      begin
        w[`DCPC_GAIN_LSB +: 7] = v.gain;
        w[`DCPC_GAIN_CAL_LSB +: 7] = r.gain;
      end
      `DCPC_OFS_RANGE:
        w[`DCPC_RANGE_LSB +: 2] = v.gain_range_select;
      `DCPC_OFS_RSET:
      begin
        // In calibration mode the enable reads back the one in use
        w[`DCPC_RSET_EN_BIT] = mode ? s.act.internal_resistor_enable
                                    : v.internal_resistor_enable;
        w[`DCPC_RSET_CAL_LSB +: 5] = r.resistor;
        w[`DCPC_RSET_LSB +: 5] = v.resistor_select;
      end
      `DCPC_OFS_CAL:
      begin
        w[`DCPC_FLAG_LSB +: 6] = r.flags;
        w[`DCPC_CAL_RESET_BIT] = s.cal_reset;
        w[`DCPC_CAL_MODE_BIT] = mode;
        w[`DCPC_CAL_EN_BIT] = s.cal_en;
        w[`DCPC_CAL_RNG_LSB +: 2] = s.cal_rng;
        w[`DCPC_CAL_CLK_EN_BIT] = s.cal_clk_en;
        w[`DCPC_CAL_DIV_LSB +: 3] = s.cal_div;
      end
      `DCPC_OFS_COFS:
      begin
        w[`DCPC_COFS_RES_LSB +: 7] = r.offset;
        w[`DCPC_CAL_DONE_BIT] = fin;
        w[`DCPC_START_BIT] = s.start_cal;
      end
      `DCPC_OFS_UPD:
        w[`DCPC_UPD_BIT] = s.upd;
      `DCPC_OFS_STAT:
      begin
        w[`DCPC_BUF_READ_BIT] = s.buf_read;
        w[`DCPC_MEM_BIT] = s.mem_access;
        w[`DCPC_PAT_BIT] = (s.pst == PAT_PLAY);
        w[`DCPC_RUN_BIT] = s.run;
      end
      `DCPC_OFS_TYPE:
        w[`DCPC_RPT_MODE_BIT] = v.repeat_mode_select;
      `DCPC_OFS_DLY:
        w[`DCPC_DLY_LSB +: 16] = v.delay;
      `DCPC_OFS_RPT:
        w[`DCPC_RPT_LSB +: 8] = v.repeat_cnt;
      default:
        w = 16'h0000;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Calibration events decoded from host writes
  assign wr_hit = reg_req.wr;
  // Start only on a 0 to 1 write so a rewrite of the same value is harmless
  assign cal_start = wr_hit && (reg_req.addr == `DCPC_OFS_COFS) &&
                     reg_req.wdata[`DCPC_START_BIT] && !q.start_cal;
  // Results clear on the falling half of the host's high-low pulse
  assign cal_clear = wr_hit && (reg_req.addr == `DCPC_OFS_CAL) &&
                     !reg_req.wdata[`DCPC_CAL_RESET_BIT] && q.cal_reset;
  // Calibrated settings are in use once a finished run is enabled
  assign cal_mode = q.cal_en && cal_done;

  ////////////////////////////////////////////////////////////////////////////
  // Calibration engine, ticking on the divided calibration clock
  dcpc_cal_engine u_cal (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(q.cal_clk_en),
    .div(q.cal_div),
    .start(cal_start),
    .clear(cal_clear),
    .meas(cal_meas),
    .res(cal_res),
    .done(cal_done),
    .cal_tick(cal_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register writes, update transfer, readback
  always_comb
  begin
    d = q;
    d.rvalid = 1'b0;
    d.start_p = 1'b0;
    d.trig_q = trigger_n;
    // Transfer pending settings, then drop the bit so reads show zero
    if (q.upd)
    begin
      d.act = q.pend;
      d.upd = 1'b0;
    end
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        `DCPC_OFS_REF:
          d.pend.ref_level_trim = reg_req.wdata[`DCPC_REF_LSB +: 6];
        `DCPC_OFS_GAIN:
          d.pend.gain = reg_req.wdata[`DCPC_GAIN_LSB +: 7];
        `DCPC_OFS_RANGE:
          d.pend.gain_range_select = reg_req.wdata[`DCPC_RANGE_LSB +: 2];
        `DCPC_OFS_RSET:
        begin
          d.pend.internal_resistor_enable = reg_req.wdata[`DCPC_RSET_EN_BIT];
          d.pend.resistor_select = reg_req.wdata[`DCPC_RSET_LSB +: 5];
        end
        `DCPC_OFS_CAL:
        begin
          d.cal_reset = reg_req.wdata[`DCPC_CAL_RESET_BIT];
          d.cal_en = reg_req.wdata[`DCPC_CAL_EN_BIT];
          d.cal_rng = reg_req.wdata[`DCPC_CAL_RNG_LSB +: 2];
          d.cal_clk_en = reg_req.wdata[`DCPC_CAL_CLK_EN_BIT];
          d.cal_div = reg_req.wdata[`DCPC_CAL_DIV_LSB +: 3];
        end
        `DCPC_OFS_COFS:
          d.start_cal = reg_req.wdata[`DCPC_START_BIT];
        `DCPC_OFS_UPD:
          d.upd = reg_req.wdata[`DCPC_UPD_BIT];
        `DCPC_OFS_STAT:
        begin
          d.buf_read = reg_req.wdata[`DCPC_BUF_READ_BIT];
          d.mem_access = reg_req.wdata[`DCPC_MEM_BIT];
          d.run = reg_req.wdata[`DCPC_RUN_BIT];
        end
        `DCPC_OFS_TYPE:
          d.pend.repeat_mode_select = reg_req.wdata[`DCPC_RPT_MODE_BIT];
        `DCPC_OFS_DLY:
          d.pend.delay = reg_req.wdata[`DCPC_DLY_LSB +: 16];
        `DCPC_OFS_RPT:
          d.pend.repeat_cnt = reg_req.wdata[`DCPC_RPT_LSB +: 8];
        default:
          d.upd = d.upd; // Unmapped writes are ignored
      endcase
    end
    // Read data held until the next read
    if (reg_req.rd)
    begin
      d.rdata = read_word(reg_req.addr, q, cal_res, cal_done, cal_mode);
      d.rvalid = 1'b1;
    end
    // Gain and resistor seen by the analog core
    d.gain_eff = cal_mode ? cal_res.gain : q.act.gain;
    d.rset_eff = cal_mode ? cal_res.resistor : q.act.resistor_select;

    // Playback sequencer, running on the active copy
    unique case (q.pst)
      PAT_IDLE:
        // Falling trigger edge, only while run permits it
        if (q.run && q.trig_q && !trigger_n)
        begin
          d.pst = PAT_DELAY;
          d.dcnt = q.act.delay;
        end
      PAT_DELAY:
        if (!q.run)
          d.pst = PAT_IDLE;
        else if (q.dcnt == 16'h0000)
        begin
          // Delay field plus one cycles have gone since the edge
          d.pst = PAT_PLAY;
          d.start_p = 1'b1;
          d.rcnt = q.act.repeat_cnt;
        end
        else
          d.dcnt = q.dcnt - 16'h0001;
      PAT_PLAY:
        if (pat_end)
        begin
          // Clearing run lets the current period finish, then stops
          if (!q.run)
            d.pst = PAT_IDLE;
          else if (q.act.repeat_mode_select)
          begin
            if (q.rcnt <= 8'h01)
              d.pst = PAT_IDLE;
            else
              d.rcnt = q.rcnt - 8'h01;
          end
        end
      default:
        d.pst = PAT_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with documented reset values
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
      q.pend.resistor_select <= `DCPC_RSET_RST;
      q.act.resistor_select <= `DCPC_RSET_RST;
      q.pend.delay <= `DCPC_DLY_RST;
      q.act.delay <= `DCPC_DLY_RST;
      q.pend.repeat_cnt <= `DCPC_RPT_RST;
      q.act.repeat_cnt <= `DCPC_RPT_RST;
      q.rset_eff <= `DCPC_RSET_RST;
      q.trig_q <= 1'b1;
      q.pst <= PAT_IDLE;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops, except pattern_active, decoded from the sequencer state, and cal_mode, gated from q.cal_en and cal_done
  assign rdata = q.rdata;
  assign rvalid = q.rvalid;
  assign act_cfg = q.act;
  assign gain_eff = q.gain_eff;
  assign rset_eff = q.rset_eff;
  assign cal_en = q.cal_en;
  assign cal_rng = q.cal_rng;
  assign mem_access = q.mem_access;
  assign pattern_active = (q.pst == PAT_PLAY);
  assign pattern_start = q.start_p;
endmodule
`default_nettype wire

// ==== testbench/dcpc_host_model.sv ====
// Host model that drives the register port as the serial port core would
`include "dcpc_defines.svh"
`default_nettype none
module dcpc_host_model import dcpc_pkg::*; (
  // Clock
  input wire logic clk,
  // Register port
  output var dcpc_pkg::dcpc_reg_req_t reg_req,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial reg_req = '0;
  ////////////////////////////////////////////////////////////////////////////
  // Idle lines are scrambled so stale data cannot pass for a request
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Data is taken in the cycle where the answer stands
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    #1;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
    d = rvalid ? rdata : 16'hdead;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Clock and circuitry on first, then start and poll the finish flag
  task automatic run_cal(output logic ok);
    logic [15:0] d;
    int n;
    ok = 1'b0;
    wr(`DCPC_OFS_CAL, 16'h0068);
    wr(`DCPC_OFS_COFS, 16'h0001);
    for (n = 0; n < 40 && !ok; n++)
    begin
      rd(`DCPC_OFS_COFS, d);
      ok = d[1];
    end
    wr(`DCPC_OFS_COFS, 16'h0000);
  endtask
  // Clear bit high, then low
  task automatic clear_cal(input logic [15:0] cfg);
    wr(`DCPC_OFS_CAL, cfg | 16'h0100);
    wr(`DCPC_OFS_CAL, cfg);
  endtask
endmodule
`default_nettype wire

// ==== testbench/dcpc_regs_bench.sv ====
// Self-checking bench of the control bank
`default_nettype none
module dcpc_regs_bench import dcpc_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [6:0] a; logic [15:0] w; logic [15:0] r0; logic [15:0] r1;} dcpc_row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic trigger_n = 1'b1;
  logic pat_end = 1'b0;
  dcpc_cal_res_t cal_meas = '{gain: 7'h55, resistor: 5'h13, offset: 7'h2a, flags: 6'h2d};
  dcpc_reg_req_t reg_req;
  dcpc_cfg_t act_cfg;
  logic [15:0] rdata;
  logic [15:0] d;
  logic [6:0] gain_eff;
  logic [4:0] rset_eff;
  logic [1:0] cal_rng;
  logic rvalid, cal_mode, cal_en, cal_tick, mem_access, pattern_active, pattern_start, ok;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  // Address, value written, reset value, value read back
  dcpc_row_t rows [9] = '{
    '{7'h03, 16'hffff, 16'h0000, 16'h003f}, '{7'h07, 16'hffff, 16'h0000, 16'h007f},
    '{7'h08, 16'hffff, 16'h0000, 16'h0003}, '{7'h0c, 16'hffff, 16'h000a, 16'h801f},
    '{7'h1f, 16'hffff, 16'h0000, 16'h0001}, '{7'h20, 16'h0003, 16'h000e, 16'h0003},
    '{7'h2b, 16'h0002, 16'h0001, 16'h0002}, '{7'h0e, 16'hff00, 16'h0000, 16'h0000},
    '{7'h05, 16'hffff, 16'h0000, 16'h0000}};
  always #5 clk = ~clk;
  dcpc_regs i_dcpc_regs (.clk(clk), .arst_n(arst_n), .reg_req(reg_req), .rdata(rdata),
    .rvalid(rvalid), .act_cfg(act_cfg), .gain_eff(gain_eff), .rset_eff(rset_eff),
    .cal_mode(cal_mode), .cal_en(cal_en), .cal_rng(cal_rng), .cal_tick(cal_tick),
    .cal_meas(cal_meas), .trigger_n(trigger_n), .pat_end(pat_end), .mem_access(mem_access),
    .pattern_active(pattern_active), .pattern_start(pattern_start));
  dcpc_host_model i_dcpc_host_model (.clk(clk), .reg_req(reg_req), .rdata(rdata),
    .rvalid(rvalid));
  ////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and hang guard
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shorthands; each returns one step after a clock edge
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    i_dcpc_host_model.wr(a, v);
  endtask
  task automatic rd(input logic [6:0] a);
    i_dcpc_host_model.rd(a, d);
  endtask
  // Trigger falls; count edges up to the start pulse
  task automatic trig();
    trigger_n = 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (!pattern_start && n < 50);
    trigger_n = 1'b1;
  endtask
  task automatic pulse_end();
    pat_end = 1'b1;
    @(posedge clk);
    #1;
    pat_end = 1'b0;
    @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: table first, then update, calibration, playback, reset
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'b1;
    foreach (rows[i])
    begin
      rd(rows[i].a);
      check("reset value", d, rows[i].r0);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      check("readback", d, rows[i].r1);
    end
    check("trim before update", act_cfg.ref_level_trim, 6'h00);
    wr(7'h1d, 16'h0001);
    rd(7'h1d);
    check("update bit", d, 16'h0000);
    check("active trim", act_cfg.ref_level_trim, 6'h3f);
    check("active delay", act_cfg.delay, 16'h0003);
    wr(7'h1e, 16'h0008);
    wr(7'h03, 16'h0005);
    rd(7'h03);
    check("active readback", d, 16'h003f);
    wr(7'h1e, 16'h0000);
    rd(7'h03);
    check("pending readback", d, 16'h0005);
    i_dcpc_host_model.run_cal(ok);
    check("calibration finished", ok, 1'b1);
    rd(7'h0e);
    check("offset result", d, 16'h2a02);
    rd(7'h07);
    check("gain result", d, 16'h557f);
    rd(7'h0c);
    check("resistor result", d, 16'h931f);
    rd(7'h0d);
    check("calibration flags", d, 16'h5ae8);
    check("offset range", cal_rng, 2'h2);
    check("calibrated gain", gain_eff, 7'h55);
    check("calibrated resistor", rset_eff, 5'h13);
    i_dcpc_host_model.clear_cal(16'h0068);
    rd(7'h0e);
    check("cleared results", d, 16'h0000);
    check("manual gain", gain_eff, 7'h7f);
    wr(7'h0d, 16'h0000);
    wr(7'h1e, 16'h0001);
    trig();
    check("start delay", n[15:0], 16'h0005);
    rd(7'h1e);
    check("playing flag", d, 16'h0003);
    pulse_end();
    check("first period", pattern_active, 1'b1);
    pulse_end();
    check("repeats done", pattern_active, 1'b0);
    wr(7'h1f, 16'h0000);
    wr(7'h1d, 16'h0001);
    wr(7'h1e, 16'h0005);
    check("memory access", mem_access, 1'b1);
    trig();
    pulse_end();
    pulse_end();
    check("continuous play", pattern_active, 1'b1);
    wr(7'h1e, 16'h0000);
    pulse_end();
    check("stopped by run", pattern_active, 1'b0);
    arst_n = 1'b0;
    @(posedge clk);
    #1;
    check("reset resistor", act_cfg.resistor_select, 5'h0a);
    check("reset delay", act_cfg.delay, 16'h000e);
    arst_n = 1'b1;
    // First request right after release must see the reset contents
    rd(7'h0c);
    check("reset readback", d, 16'h000a);
    complete_run();
  end
endmodule
`default_nettype wire

// ==== testbench/dcpc_regs_properties.sv ====
// Port checks of the control bank
`include "dcpc_defines.svh"
`default_nettype none
module dcpc_regs_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire dcpc_pkg::dcpc_reg_req_t reg_req,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  // Analog control
  input wire dcpc_pkg::dcpc_cfg_t act_cfg,
  input wire logic [6:0] gain_eff,
  input wire logic [4:0] rset_eff,
  input wire logic cal_mode,
  input wire logic cal_en,
  input wire logic [1:0] cal_rng,
  input wire logic cal_tick,
  // Pattern side
  input wire logic pat_end,
  input wire logic mem_access,
  input wire logic pattern_active,
  input wire logic pattern_start
);
  import dcpc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  // Decoded writes; only the update write may move the active copy
  logic upd_wr;
  assign upd_wr = reg_req.wr && reg_req.addr == `DCPC_OFS_UPD && reg_req.wdata[0];
  sequence s_wr(ofs);
    reg_req.wr && reg_req.addr == ofs;
  endsequence
  sequence s_rd(ofs);
    reg_req.rd && reg_req.addr == ofs;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // Register port and control fields
  a_read_answer: assert property (reg_req.rd |=> rvalid)
    else $error("read got no answer");
  a_read_cause: assert property (rvalid |-> $past(reg_req.rd))
    else $error("answer without a read");
  a_mem_follow: assert property (s_wr(`DCPC_OFS_STAT) |=>
    mem_access == $past(reg_req.wdata[2]))
    else $error("memory access enable wrong");
  a_cal_fields: assert property (s_wr(`DCPC_OFS_CAL) |=> cal_en == $past(reg_req.wdata[6])
    && cal_rng == $past(reg_req.wdata[5:4]))
    else $error("calibration enable or range wrong");
  // A stopped calibration clock may still have one tick in flight
  a_tick_gate: assert property (s_wr(`DCPC_OFS_CAL) ##0 !reg_req.wdata[3] |-> ##3 !cal_tick [*3])
    else $error("calibration tick while clock gated");
  a_update_copy: assert property ($changed(act_cfg) |-> $past(upd_wr) || $past(upd_wr, 2))
    else $error("active copy moved without update");
  a_gain_select: assert property (!cal_mode && $past(!cal_mode) && $stable(act_cfg)
    |-> gain_eff == act_cfg.gain && rset_eff == act_cfg.resistor_select)
    else $error("manual settings not in use");
  // The mode flag read back must match the selection driving the analog core
  a_cal_mode_read: assert property (s_rd(`DCPC_OFS_CAL) |=>
    rdata[`DCPC_CAL_MODE_BIT] == $past(cal_mode))
    else $error("calibration mode bit wrong");
  ////////////////////////////////////////////////////////////////////////////
  // Pattern playback
  a_start_pulse: assert property (pattern_start |->
    pattern_active && !$past(pattern_active))
    else $error("start pulse not at first play cycle");
  a_stop_end: assert property ($fell(pattern_active) |-> $past(pat_end))
    else $error("pattern stopped before period end");
endmodule
bind dcpc_regs dcpc_regs_properties i_dcpc_regs_properties (
  .clk(clk), .arst_n(arst_n), .reg_req(reg_req), .rdata(rdata), .rvalid(rvalid),
  .act_cfg(act_cfg),
  .gain_eff(gain_eff), .rset_eff(rset_eff), .cal_mode(cal_mode), .cal_en(cal_en),
  .cal_rng(cal_rng), .cal_tick(cal_tick), .pat_end(pat_end), .mem_access(mem_access),
  .pattern_active(pattern_active), .pattern_start(pattern_start)
);
`default_nettype wire
